// >>> hw/ttf_consts.vh
`ifndef TTF_CONSTS_VH
`define TTF_CONSTS_VH

// apb register byte offsets
`define TTF_OFF_CTRL 12'h000
`define TTF_OFF_ON_SET 12'h004
`define TTF_OFF_OFF_SET 12'h008
`define TTF_OFF_CYCLE 12'h00C
`define TTF_OFF_DUTY 12'h010
`define TTF_OFF_STATUS 12'h014
`define TTF_OFF_PV 12'h018
`define TTF_OFF_DISP 12'h01C
`define TTF_OFF_DIP 12'h020
`define TTF_OFF_CMD 12'h024

// control register fields
`define TTF_C_TWIN 0
`define TTF_C_MODE_Z 1
`define TTF_C_START_ON 2
`define TTF_C_DOWN 3
`define TTF_C_FAST 4
`define TTF_C_PNP 5
`define TTF_C_COLOR_LO 6
`define TTF_C_COLOR_HI 7
`define TTF_C_ONRNG_LO 8
`define TTF_C_ONRNG_HI 10
`define TTF_C_OFFRNG_LO 11
`define TTF_C_OFFRNG_HI 13
`define TTF_C_ITEM 14

// command register bits
`define TTF_K_RESET_KEY 0
`define TTF_K_CPU_FAULT 1
`define TTF_K_RAM_FAULT 2
`define TTF_K_NV_FAULT 3

// dip switch pin positions (pin n at bit n-1)
`define TTF_DIP_ENABLE 0
`define TTF_DIP_OFFRNG_LO 1
`define TTF_DIP_OFFRNG_HI 2
`define TTF_DIP_ONRNG_LO 3
`define TTF_DIP_ONRNG_HI 4
`define TTF_DIP_START_ON 5
`define TTF_DIP_DOWN 6
`define TTF_DIP_FAST 7

// time ranges: 0 = 0.01 s, 1 = 0.1 s, 2 = 1 s, 3 = min-s, 4 = 0.001 s, 5 = 1 min, 6 = 1 h
`define TTF_RNG_10MS 3'h0
`define TTF_RNG_100MS 3'h1
`define TTF_RNG_1S 3'h2
`define TTF_RNG_MINSEC 3'h3
`define TTF_RNG_1MS 3'h4
`define TTF_RNG_1MIN 3'h5
`define TTF_RNG_1H 3'h6

// display codes
`define TTF_CODE_NONE 2'h0
`define TTF_CODE_CPU 2'h1
`define TTF_CODE_MEM 2'h2
`define TTF_SUB_DARK 2'h0
`define TTF_SUB_CYCLE 2'h1
`define TTF_SUB_DUTY 2'h2
`define TTF_SUB_NVSUB 2'h3

// colors
`define TTF_COL_RED 2'h0
`define TTF_COL_GREEN 2'h1
`define TTF_COL_RG 2'h2
`define TTF_COL_GR 2'h3

// timing
`define TTF_CLK_HZ 40000000
`define TTF_TICK_US 1000
`define TTF_WIDTH_SLOW_MS 20
`define TTF_WIDTH_FAST_MS 1
`define TTF_DUTY_FULL 7'h64
`define TTF_PCT_DIV 100
`define TTF_MINSEC_UNITS 60

`endif

// >>> hw/ttf_timer.v
// Behaviour
// RULE1: duty mode on time is cycle times duty over 100, rounded to range resolution.
// RULE2: duty setting accepts integers 0 to 100 inclusive.
// RULE3: duty mode with zero cycle time keeps output off.
// RULE4: duty mode with zero duty keeps output off.
// RULE5: duty mode with full duty keeps output on.
// RULE6: cycle item shows present value, cycle time and lights cycle indicator.
// RULE7: cpu fault shows cpu code, sub dark; reset key or power clears it.
// RULE8: ram fault shows memory code, output off, only power cycle recovers.
// RULE9: nonvolatile fault shows memory code with subcode; reset key restores factory, set zero.
// RULE10: dip settings apply only when pin 1 is on.
// RULE11: dip switches are sampled only at power-up.
// RULE12: start mode picks off-first or on-first; dip pin 6.
// RULE13: count direction by dip pin 7 or key; up elapsed, down remaining.
// RULE14: inputs shorter than 20 ms or 1 ms (pin 8) are rejected, shared setting.
// RULE15: on range selectable from 0.001 s to 9999 h.
// RULE16: off range selectable from 0.000 s to 9999 h.
// RULE17: dip selects only four ranges per interval; others by key setting.
// RULE18: one polarity setting governs all external inputs.
// RULE19: present value color fixed red, fixed green, red/green, green/red.
// RULE20: factory state is all dip off and single-timer operation.
// RULE21: duty item shows present value, duty and lights duty indicator.
// RULE22: twin timer alternates on and off, restarting at start phase on reset.
// RULE23: outside party holds each input at least the minimum width.
//
// Implementation choices: the placing of the registers and the APB register port.
`include "ttf_consts.vh"

module ttf_timer #(
   parameter CNT_W = 32,
   parameter DIP_W = 8,
   parameter TICK_CYC = (`TTF_CLK_HZ / 1000000) * `TTF_TICK_US,
   parameter SLOW_TICKS = `TTF_WIDTH_SLOW_MS,
   parameter FAST_TICKS = `TTF_WIDTH_FAST_MS
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // external inputs and straps
   input wire [DIP_W-1:0] dip_sw,
   input wire sig_in,
   input wire reset_in,
   input wire gate_in,
   // output and display
   output reg out_on,
   output reg [CNT_W-1:0] main_value,
   output reg [CNT_W-1:0] sub_value,
   output reg [1:0] main_code,
   output reg [1:0] sub_code,
   output reg duty_item_indicator,
   output reg cycle_item_indicator,
   output reg pv_green
);

   // ==========================================
   // registers
   reg [14:0] ctrl_reg;
   reg [CNT_W-1:0] on_set_reg;
   reg [CNT_W-1:0] off_set_reg;
   reg [CNT_W-1:0] cycle_reg;
   reg [6:0] duty_reg;
   reg [DIP_W-1:0] dip_reg;
   reg dip_taken_reg;
   reg cpu_fault_reg;
   reg ram_fault_reg;
   reg nv_fault_reg;
   reg phase_on_reg;
   reg run_reg;
   reg [CNT_W-1:0] elapsed_reg;
   reg [15:0] tick_cnt_reg;
   reg tick_reg;
   reg [5:0] sub_cnt_reg;
   wire [2:0] flt_q;

   wire wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // effective settings: dip overrides keys when pin 1 on
   wire dip_on = dip_reg[`TTF_DIP_ENABLE];
   wire mode_z = ctrl_reg[`TTF_C_MODE_Z];
   wire twin = ctrl_reg[`TTF_C_TWIN] | mode_z;
   wire start_on = dip_on ? dip_reg[`TTF_DIP_START_ON] : ctrl_reg[`TTF_C_START_ON]; // [RULE10] [RULE12]
   wire count_down = dip_on ? dip_reg[`TTF_DIP_DOWN] : ctrl_reg[`TTF_C_DOWN]; // [RULE13]
   wire fast_in = dip_on ? dip_reg[`TTF_DIP_FAST] : ctrl_reg[`TTF_C_FAST]; // [RULE14]
   // dip gives the four low range codes only
   wire [2:0] on_rng = dip_on ? {1'b0, dip_reg[`TTF_DIP_ONRNG_HI:`TTF_DIP_ONRNG_LO]}
                              : ctrl_reg[`TTF_C_ONRNG_HI:`TTF_C_ONRNG_LO]; // [RULE15] [RULE17]
   wire [2:0] off_rng = dip_on ? {1'b0, dip_reg[`TTF_DIP_OFFRNG_HI:`TTF_DIP_OFFRNG_LO]}
                               : ctrl_reg[`TTF_C_OFFRNG_HI:`TTF_C_OFFRNG_LO]; // [RULE16] [RULE17]

   // ==========================================
   // power-up dip capture and key registers
   // straps are read once; later changes wait for the next power-up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dip_reg <= {DIP_W{1'b0}};
         dip_taken_reg <= 1'b0;
         ctrl_reg <= 15'h0000; // [RULE20]
         on_set_reg <= {CNT_W{1'b0}};
         off_set_reg <= {CNT_W{1'b0}};
         cycle_reg <= {CNT_W{1'b0}};
         duty_reg <= 7'h00;
         cpu_fault_reg <= 1'b0;
         ram_fault_reg <= 1'b0;
         nv_fault_reg <= 1'b0;
      end else begin
         if (!dip_taken_reg) begin
            dip_reg <= dip_sw; // [RULE11]
            dip_taken_reg <= 1'b1;
         end
         if (wr_en) begin
            case (paddr)
               `TTF_OFF_CTRL: ctrl_reg <= pwdata[14:0];
               `TTF_OFF_ON_SET: on_set_reg <= pwdata[CNT_W-1:0];
               `TTF_OFF_OFF_SET: off_set_reg <= pwdata[CNT_W-1:0];
               `TTF_OFF_CYCLE: cycle_reg <= pwdata[CNT_W-1:0];
               // duty above full scale is refused, old value kept
               `TTF_OFF_DUTY: begin
                  if (pwdata[31:0] <= {25'h000_0000, `TTF_DUTY_FULL})
                     duty_reg <= pwdata[6:0]; // [RULE2]
               end
               // a fault set in the same write beats the reset key
               `TTF_OFF_CMD: begin
                  if (pwdata[`TTF_K_CPU_FAULT])
                     cpu_fault_reg <= 1'b1;
                  else if (pwdata[`TTF_K_RESET_KEY])
                     cpu_fault_reg <= 1'b0; // [RULE7]
                  if (pwdata[`TTF_K_RAM_FAULT])
                     ram_fault_reg <= 1'b1; // [RULE8]
                  if (pwdata[`TTF_K_NV_FAULT]) begin
                     nv_fault_reg <= 1'b1;
                  end else if (pwdata[`TTF_K_RESET_KEY] && nv_fault_reg) begin
                     nv_fault_reg <= 1'b0; // [RULE9]
                     ctrl_reg <= 15'h0000;
                     on_set_reg <= {CNT_W{1'b0}};
                     off_set_reg <= {CNT_W{1'b0}};
                     cycle_reg <= {CNT_W{1'b0}};
                     duty_reg <= 7'h00;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // 1 ms time base
   // one-cycle enable pulse every TICK_CYC clocks
   localparam integer TICK_LAST = TICK_CYC - 1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == TICK_LAST[15:0]) begin
         tick_cnt_reg <= 16'h0000;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ==========================================
   // input polarity and width filters
   wire [2:0] raw_in = {gate_in, reset_in, sig_in} ^ {3{~ctrl_reg[`TTF_C_PNP]}}; // [RULE18]
   wire [4:0] need_ticks = fast_in ? FAST_TICKS[4:0] : SLOW_TICKS[4:0]; // [RULE14]
   // filtered level lags the pin by the width less up to one tick
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_flt
         reg q_reg;
         reg [4:0] cnt_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q_reg <= 1'b0;
               cnt_reg <= 5'h00;
            end else if (raw_in[gi] == q_reg) begin
               cnt_reg <= 5'h00; // chatter restarts count [RULE14]
            end else if (tick_reg) begin
               if (cnt_reg + 5'h01 >= need_ticks) begin
                  q_reg <= raw_in[gi]; // [RULE23]
                  cnt_reg <= 5'h00;
               end else begin
                  cnt_reg <= cnt_reg + 5'h01;
               end
            end
         end
         assign flt_q[gi] = q_reg;
      end
   endgenerate
   wire rst_act = flt_q[1];
   wire gate_act = flt_q[2];

   // ==========================================
   // duty on time, rounded to range units
   // set values are in range units, so rounding is half up on the unit
   wire [CNT_W+6:0] prod = cycle_reg * duty_reg;
   wire [CNT_W+6:0] duty_on_full = (prod + (`TTF_PCT_DIV / 2)) / `TTF_PCT_DIV; // [RULE1]
   wire [CNT_W-1:0] duty_on = duty_on_full[CNT_W-1:0];
   wire [CNT_W-1:0] duty_off = cycle_reg - duty_on;

   // milliseconds (1 ms ticks) per sub-tick of range resolution
   function [15:0] rng_ms;
      input [2:0] r;
      begin
         case (r)
            `TTF_RNG_1MS: rng_ms = 16'h0001;
            `TTF_RNG_10MS: rng_ms = 16'h000A;
            `TTF_RNG_100MS: rng_ms = 16'h0064;
            default: rng_ms = 16'h03E8;
         endcase
      end
   endfunction

   wire [CNT_W-1:0] cur_set = mode_z ? (phase_on_reg ? duty_on : duty_off)
                                     : (phase_on_reg ? on_set_reg : off_set_reg);
   wire [2:0] cur_rng = phase_on_reg ? on_rng : off_rng;
   // min-s, minute and hour ranges step in seconds, minutes, hours
   localparam integer MINSEC_LAST = `TTF_MINSEC_UNITS - 1;
   wire [5:0] sub_last = MINSEC_LAST[5:0];
   wire [5:0] sub_max = (cur_rng == `TTF_RNG_1MIN || cur_rng == `TTF_RNG_1H) ? sub_last : 6'd0;
   reg [15:0] ms_cnt_reg;
   // hour range counts sixty minute units
   reg [5:0] hr_cnt_reg;
   wire hr_step = (hr_cnt_reg == sub_last);
   wire unit_tick = tick_reg && (ms_cnt_reg == rng_ms(cur_rng) - 16'h0001);
   wire unit_step = unit_tick && (sub_cnt_reg == sub_max) && (cur_rng != `TTF_RNG_1H || hr_step);

   // ==========================================
   // twin timer sequencing
   // a fresh enable restarts, so every run begins in the start phase
   wire restart = rst_act || !dip_taken_reg || !run_reg;
   // the phase flips on its last unit: a set of n units lasts n units
   wire last_unit = (elapsed_reg == cur_set - {{(CNT_W-1){1'b0}}, 1'b1});
   // gate holds the timer without losing time already counted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= 1'b0;
         phase_on_reg <= 1'b0;
         elapsed_reg <= {CNT_W{1'b0}};
         ms_cnt_reg <= 16'h0000;
         sub_cnt_reg <= 6'h00;
         hr_cnt_reg <= 6'h00;
      end else begin
         run_reg <= twin;
         if (restart) begin
            phase_on_reg <= start_on; // [RULE22] [RULE12]
            elapsed_reg <= {CNT_W{1'b0}};
            ms_cnt_reg <= 16'h0000;
            sub_cnt_reg <= 6'h00;
            hr_cnt_reg <= 6'h00;
         end else if (twin && !gate_act && tick_reg) begin
            if (elapsed_reg >= cur_set) begin
               // zero or shortened set: leave the phase at once
               phase_on_reg <= ~phase_on_reg; // [RULE22]
               elapsed_reg <= {CNT_W{1'b0}};
               ms_cnt_reg <= 16'h0000;
               sub_cnt_reg <= 6'h00;
               hr_cnt_reg <= 6'h00;
            end else if (unit_tick) begin
               ms_cnt_reg <= 16'h0000;
               if (sub_cnt_reg == sub_max) begin
                  sub_cnt_reg <= 6'h00;
                  if (cur_rng == `TTF_RNG_1H)
                     hr_cnt_reg <= hr_step ? 6'h00 : hr_cnt_reg + 6'h01;
                  if (unit_step && last_unit) begin
                     phase_on_reg <= ~phase_on_reg; // [RULE22] [RULE1]
                     elapsed_reg <= {CNT_W{1'b0}};
                     hr_cnt_reg <= 6'h00;
                  end else if (unit_step) begin
                     elapsed_reg <= elapsed_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                  end
               end else begin
                  sub_cnt_reg <= sub_cnt_reg + 6'h01;
               end
            end else begin
               ms_cnt_reg <= ms_cnt_reg + 16'h0001;
            end
         end
      end
   end

   // ==========================================
   // output, display, color
   wire [CNT_W-1:0] remain = cur_set - elapsed_reg;
   reg out_next;
   always @* begin
      if (!mode_z)
         out_next = twin & phase_on_reg;
      else if (cycle_reg == {CNT_W{1'b0}})
         out_next = 1'b0; // [RULE3]
      else if (duty_reg == 7'h00)
         out_next = 1'b0; // [RULE4]
      else if (duty_reg == `TTF_DUTY_FULL)
         out_next = 1'b1; // [RULE5]
      else
         out_next = phase_on_reg;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_on <= 1'b0;
         main_value <= {CNT_W{1'b0}};
         sub_value <= {CNT_W{1'b0}};
         main_code <= `TTF_CODE_NONE;
         sub_code <= `TTF_SUB_DARK;
         duty_item_indicator <= 1'b0;
         cycle_item_indicator <= 1'b0;
         pv_green <= 1'b0;
      end else begin
         // any fault holds the output off
         out_on <= out_next & ~ram_fault_reg & ~cpu_fault_reg & ~nv_fault_reg; // [RULE8]
         main_value <= count_down ? remain : elapsed_reg; // [RULE13]
         duty_item_indicator <= 1'b0;
         cycle_item_indicator <= 1'b0;
         if (ram_fault_reg) begin
            main_code <= `TTF_CODE_MEM; // [RULE8]
            sub_code <= `TTF_SUB_DARK;
         end else if (nv_fault_reg) begin
            main_code <= `TTF_CODE_MEM; // [RULE9]
            sub_code <= `TTF_SUB_NVSUB;
         end else if (cpu_fault_reg) begin
            main_code <= `TTF_CODE_CPU; // [RULE7]
            sub_code <= `TTF_SUB_DARK;
         end else if (mode_z && ctrl_reg[`TTF_C_ITEM]) begin
            main_code <= `TTF_CODE_NONE;
            sub_code <= `TTF_SUB_CYCLE;
            sub_value <= cycle_reg; // [RULE6]
            cycle_item_indicator <= 1'b1;
         end else if (mode_z) begin
            main_code <= `TTF_CODE_NONE;
            sub_code <= `TTF_SUB_DUTY;
            sub_value <= {{(CNT_W-7){1'b0}}, duty_reg}; // [RULE21]
            duty_item_indicator <= 1'b1;
         end else begin
            main_code <= `TTF_CODE_NONE;
            sub_code <= `TTF_SUB_DARK;
            sub_value <= cur_set;
         end
         case (ctrl_reg[`TTF_C_COLOR_HI:`TTF_C_COLOR_LO])
            `TTF_COL_RED: pv_green <= 1'b0; // [RULE19]
            `TTF_COL_GREEN: pv_green <= 1'b1;
            `TTF_COL_RG: pv_green <= out_next;
            default: pv_green <= ~out_next;
         endcase
      end
   end

   // ==========================================
   // apb read
   // unmapped offsets read as zero
   wire [31:0] status_word = {25'h000_0000, flt_q, out_on, nv_fault_reg, ram_fault_reg, cpu_fault_reg};
   wire [31:0] disp_word = {26'h000_0000, phase_on_reg, dip_on, sub_code, main_code};
   always @* begin
      case (paddr)
         `TTF_OFF_CTRL: prdata = {17'h0_0000, ctrl_reg};
         `TTF_OFF_ON_SET: prdata = on_set_reg;
         `TTF_OFF_OFF_SET: prdata = off_set_reg;
         `TTF_OFF_CYCLE: prdata = cycle_reg;
         `TTF_OFF_DUTY: prdata = {25'h000_0000, duty_reg};
         `TTF_OFF_STATUS: prdata = status_word;
         `TTF_OFF_PV: prdata = main_value;
         `TTF_OFF_DISP: prdata = disp_word;
         `TTF_OFF_DIP: prdata = {{(32-DIP_W){1'b0}}, dip_reg};
         default: prdata = 32'h0000_0000;
      endcase
   end

endmodule

// >>> testbench/ttf_timer_properties.sv
`include "ttf_consts.vh"
module ttf_timer_properties (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // output and display
   input wire out_on,
   input wire [1:0] main_code,
   input wire [1:0] sub_code,
   input wire duty_item_indicator,
   input wire cycle_item_indicator
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================
   // mirror of duty mode settings
   logic zm, cz, dz, df;
   logic [2:0] quiet;
   wire wr = psel && penable && pwrite;
   wire nv_clr = wr && paddr == `TTF_OFF_CMD && pwdata[0] && sub_code == `TTF_SUB_NVSUB;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn || nv_clr) begin
         zm <= 1'b0;
         cz <= 1'b1;
         dz <= 1'b1;
         df <= 1'b0;
         quiet <= 3'h0;
      end else begin
         quiet <= wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
         if (wr && paddr == `TTF_OFF_CTRL)
            zm <= pwdata[`TTF_C_MODE_Z];
         if (wr && paddr == `TTF_OFF_CYCLE)
            cz <= pwdata == 32'h0000_0000;
         if (wr && paddr == `TTF_OFF_DUTY && pwdata <= 32'h0000_0064) begin
            dz <= pwdata == 32'h0000_0000;
            df <= pwdata == 32'h0000_0064;
         end
      end
   end
   // ======================================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ram;
      main_code == `TTF_CODE_MEM && sub_code == `TTF_SUB_DARK;
   endsequence
   sequence s_settled;
      quiet == 3'h7 && zm;
   endsequence
   chk_cpu_sub_dark: assert property (main_code == `TTF_CODE_CPU |-> sub_code == `TTF_SUB_DARK)
      else $error("cpu code shown with lit sub display");
   chk_ram_out_off: assert property (s_ram ##1 s_ram |-> !out_on)
      else $error("output on during memory fault");
   chk_ram_sticky: assert property (s_ram |=> s_ram)
      else $error("memory fault left without power cycle");
   chk_nv_subcode: assert property (sub_code == `TTF_SUB_NVSUB |-> main_code == `TTF_CODE_MEM)
      else $error("nonvolatile subcode without memory code");
   chk_cycle_item: assert property (main_code == `TTF_CODE_NONE && cycle_item_indicator |->
      sub_code == `TTF_SUB_CYCLE && !duty_item_indicator) else $error("cycle item display wrong");
   chk_duty_item: assert property (main_code == `TTF_CODE_NONE && duty_item_indicator |->
      sub_code == `TTF_SUB_DUTY && !cycle_item_indicator) else $error("duty item display wrong");
   chk_zero_off: assert property (s_settled ##0 (cz || dz) |-> !out_on)
      else $error("output on with zero cycle or duty");
   chk_full_on: assert property (s_settled ##0 (df && !cz && main_code == `TTF_CODE_NONE) |-> out_on)
      else $error("output off at full duty");
endmodule
bind ttf_timer ttf_timer_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .out_on(out_on), .main_code(main_code),
   .sub_code(sub_code), .duty_item_indicator(duty_item_indicator), .cycle_item_indicator(cycle_item_indicator));

// >>> testbench/ttf_ext_model.sv
module ttf_ext_model (
   // clock and polarity
   input wire pclk,
   input wire active_high,
   // timer inputs
   output wire sig_in,
   output wire reset_in,
   output wire gate_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] act = 3'h0;
   // idle level is the inverse of the active level
   assign sig_in = ~(act[0] ^ active_high);
   assign reset_in = ~(act[1] ^ active_high);
   assign gate_in = ~(act[2] ^ active_high);
   // short pulses break the width rule on purpose
   task automatic pulse(input int which, input int cycles);
      @(posedge pclk);
      act[which] <= 1'b1;
      repeat (cycles) @(posedge pclk);
      act[which] <= 1'b0;
   endtask
endmodule

// >>> testbench/tb_top.sv
`include "ttf_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, act_hi = 0, seen;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, q, a;
   logic [7:0] dip_sw = 8'h00;
   wire [31:0] prdata, main_value, sub_value;
   wire pready, pslverr, sig_in, reset_in, gate_in, out_on, duty_item_indicator, cycle_item_indicator, pv_green;
   wire [1:0] main_code, sub_code;
   int err_count = 0, comparisons = 0, cyc = 0, hi, lo;
   always #12.5 pclk = ~pclk;
   ttf_timer #(.TICK_CYC(TICK)) u_ttf_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dip_sw(dip_sw), .sig_in(sig_in), .reset_in(reset_in), .gate_in(gate_in), .out_on(out_on),
      .main_value(main_value), .sub_value(sub_value), .main_code(main_code), .sub_code(sub_code),
      .duty_item_indicator(duty_item_indicator), .cycle_item_indicator(cycle_item_indicator), .pv_green(pv_green));
   ttf_ext_model u_ttf_ext_model (.pclk(pclk), .active_high(act_hi), .sig_in(sig_in), .reset_in(reset_in),
      .gate_in(gate_in));
   // ======================================================
   // bus and helpers
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0000_0000);
      `CHK(q, e)
   endtask
   task automatic pwr(input logic [7:0] d);
      dip_sw <= d;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task automatic meas;
      while (out_on === 1'b1) @(posedge pclk);
      while (out_on !== 1'b1) @(posedge pclk);
      hi = 0;
      lo = 0;
      while (out_on === 1'b1) begin hi++; @(posedge pclk); end
      while (out_on === 1'b0) begin lo++; @(posedge pclk); end
      hi = (hi + TICK / 2) / TICK;
      lo = (lo + TICK / 2) / TICK;
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
   endtask
   // ======================================================
   // scenarios
   task automatic t_start;
      rd(`TTF_OFF_CTRL, 32'h0000_0000);
      rd(`TTF_OFF_DIP, 32'h0000_0000);
      dip_sw <= 8'h21;
      rd(`TTF_OFF_DIP, 32'h0000_0000);
      pwr(8'h21);
      rd(`TTF_OFF_DIP, 32'h0000_0021);
      rd(`TTF_OFF_DISP, 32'h0000_0030);
      pwr(8'h20);
      rd(`TTF_OFF_DISP, 32'h0000_0000);
      pwr(8'h00);
   endtask
   task automatic t_duty(input logic [31:0] c, input logic [31:0] d, input int eh, input int el);
      wr(`TTF_OFF_CTRL, 32'h0000_0000);
      wr(`TTF_OFF_CYCLE, c);
      wr(`TTF_OFF_DUTY, d);
      wr(`TTF_OFF_CTRL, 32'h0000_6402);
      meas;
      `CHK(hi, eh)
      `CHK(lo, el)
      `CHK(cycle_item_indicator, 1'b1)
      `CHK(sub_value, c)
      wr(`TTF_OFF_CTRL, 32'h0000_2402);
      settle;
      `CHK(duty_item_indicator, 1'b1)
      `CHK(sub_value, d)
   endtask
   task automatic t_flat(input logic [31:0] c, input logic [31:0] d, input logic e);
      wr(`TTF_OFF_CTRL, 32'h0000_0000);
      wr(`TTF_OFF_CYCLE, c);
      wr(`TTF_OFF_DUTY, d);
      wr(`TTF_OFF_CTRL, 32'h0000_6482);
      repeat (8) @(posedge pclk);
      repeat (40) begin
         `CHK(out_on, e)
         `CHK(pv_green, e)
         @(posedge pclk);
      end
   endtask
   task automatic t_twin;
      wr(`TTF_OFF_CTRL, 32'h0000_0000);
      wr(`TTF_OFF_ON_SET, 32'h0000_0003);
      wr(`TTF_OFF_OFF_SET, 32'h0000_0005);
      wr(`TTF_OFF_CTRL, 32'h0000_2405);
      settle;
      `CHK(out_on, 1'b1)
      meas;
      `CHK(hi, 3)
      `CHK(lo, 5)
      wr(`TTF_OFF_CTRL, 32'h0000_0000);
      wr(`TTF_OFF_CTRL, 32'h0000_2401);
      settle;
      `CHK(out_on, 1'b0)
      wr(`TTF_OFF_OFF_SET, 32'h0000_0032);
      for (int dn = 0; dn < 2; dn++) begin
         wr(`TTF_OFF_CTRL, 32'h0000_0000);
         wr(`TTF_OFF_CTRL, 32'h0000_2401 | (dn << 3));
         repeat (8) @(posedge pclk);
         apb(1'b0, `TTF_OFF_PV, 32'h0000_0000);
         a = q;
         repeat (12) @(posedge pclk);
         apb(1'b0, `TTF_OFF_PV, 32'h0000_0000);
         `CHK(dn ? q < a : q > a, 1'b1)
      end
   endtask
   task automatic t_filter(input logic fast, input int which, input int w, input logic pol, input logic e);
      wr(`TTF_OFF_CTRL, {26'h0, pol, fast, 4'h0});
      act_hi <= pol;
      repeat (30 * TICK) @(posedge pclk);
      seen = 1'b0;
      fork
         u_ttf_ext_model.pulse(which, w * TICK);
         repeat ((w + 25) * TICK / 3) begin
            apb(1'b0, `TTF_OFF_STATUS, 32'h0000_0000);
            seen = seen | q[4 + which];
         end
      join
      `CHK(seen, e)
   endtask
   task automatic t_fault;
      wr(`TTF_OFF_ON_SET, 32'h0000_0007);
      wr(`TTF_OFF_CMD, 32'h0000_0002);
      settle;
      `CHK(main_code, `TTF_CODE_CPU)
      `CHK(sub_code, `TTF_SUB_DARK)
      wr(`TTF_OFF_CMD, 32'h0000_0001);
      settle;
      `CHK(main_code, `TTF_CODE_NONE)
      rd(`TTF_OFF_ON_SET, 32'h0000_0007);
      wr(`TTF_OFF_CMD, 32'h0000_0008);
      settle;
      `CHK(main_code, `TTF_CODE_MEM)
      `CHK(sub_code, `TTF_SUB_NVSUB)
      wr(`TTF_OFF_CMD, 32'h0000_0001);
      settle;
      `CHK(main_code, `TTF_CODE_NONE)
      rd(`TTF_OFF_ON_SET, 32'h0000_0000);
      wr(`TTF_OFF_ON_SET, 32'h0000_0007);
      wr(`TTF_OFF_CTRL, 32'h0000_2405);
      wr(`TTF_OFF_CMD, 32'h0000_0004);
      settle;
      `CHK(main_code, `TTF_CODE_MEM)
      `CHK(out_on, 1'b0)
      wr(`TTF_OFF_CMD, 32'h0000_0001);
      settle;
      `CHK(main_code, `TTF_CODE_MEM)
      pwr(8'h00);
      `CHK(main_code, `TTF_CODE_NONE)
   endtask
   // ======================================================
   // run control
   task automatic report_and_stop;
      if (err_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      pwr(8'h00);
      t_start;
      t_duty(32'h0000_0014, 32'h0000_001F, 6, 14);
      t_duty(32'h0000_000A, 32'h0000_0019, 3, 7);
      t_flat(32'h0000_0000, 32'h0000_0032, 1'b0);
      t_flat(32'h0000_000A, 32'h0000_0000, 1'b0);
      t_flat(32'h0000_0000, 32'h0000_0064, 1'b0);
      t_flat(32'h0000_000A, 32'h0000_0064, 1'b1);
      wr(`TTF_OFF_DUTY, 32'h0000_0065);
      rd(`TTF_OFF_DUTY, 32'h0000_0064);
      t_twin;
      t_filter(1'b0, 0, 10, 1'b0, 1'b0);
      t_filter(1'b0, 1, 30, 1'b0, 1'b1);
      t_filter(1'b1, 2, 3, 1'b1, 1'b1);
      t_filter(1'b0, 2, 10, 1'b1, 1'b0);
      t_fault;
      report_and_stop;
   end
endmodule
